/* core/wdg_top.sv */
// Countdown watchdog with interrupt and system reset, AXI4-Lite slave
`timescale 1ns/1ps

module wdg_top
  import wdg_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC_DFLT
) (
  input  wire logic        CORE_CLK,       // 250 MHz core clock
  input  wire logic        RST_B,          // Async reset, active low
  input  wire logic        FRZ_SET,        // Freeze request pin
  input  wire logic        FRZ_CLR,        // Resume request pin
  input  wire logic        DBG_HALT,       // Processor halted in debug
  output logic             NMI_O,          // Non-maskable interrupt
  output logic             SYS_RST_REQ,    // System reset request
  input  wire logic        S_AXI_AWVALID,  // Write address valid
  output logic             S_AXI_AWREADY,  // Write address ready
  input  wire logic [31:0] S_AXI_AWADDR,   // Write address
  input  wire logic [2:0]  S_AXI_AWPROT,   // Write protection, unused
  input  wire logic        S_AXI_WVALID,   // Write data valid
  output logic             S_AXI_WREADY,   // Write data ready
  input  wire logic [31:0] S_AXI_WDATA,    // Write data
  input  wire logic [3:0]  S_AXI_WSTRB,    // Write byte strobes
  output logic             S_AXI_BVALID,   // Write response valid
  input  wire logic        S_AXI_BREADY,   // Write response ready
  output logic [1:0]       S_AXI_BRESP,    // Write response
  input  wire logic        S_AXI_ARVALID,  // Read address valid
  output logic             S_AXI_ARREADY,  // Read address ready
  input  wire logic [31:0] S_AXI_ARADDR,   // Read address
  input  wire logic [2:0]  S_AXI_ARPROT,   // Read protection, unused
  output logic             S_AXI_RVALID,   // Read data valid
  input  wire logic        S_AXI_RREADY,   // Read data ready
  output logic [31:0]      S_AXI_RDATA,    // Read data
  output logic [1:0]       S_AXI_RRESP     // Read response
);

  localparam logic [PRE_W-1:0] TICK_LAST = PRE_W'(TICK_CYCLES - 1);

  wdg_state_t s;
  wdg_state_t n;
  logic       halt;
  logic       run;
  logic       tick;
  logic       wr_go;
  logic       wr_cnt;
  logic       wr_ctl;
  logic       key_ok;
  logic       rst_hit;
  logic       nmi_hit;
  logic [8:0] rd_cnt;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    // Pins pass two flops; only the second stage is used below
    n.sync1 = {DBG_HALT, FRZ_CLR, FRZ_SET};
    n.sync2 = s.sync1;
    halt    = s.sync2[2];

    // Freeze latch; a set seen together with a clear wins
    if (s.sync2[1]) begin
      n.frz = 1'b0;
    end
    if (s.sync2[0]) begin
      n.frz = 1'b1;
    end
    // Debug halt always stops; the latch only counts in mode 0
    run  = !halt && !(s.frz && !s.mode);
    tick = run && (s.pre == TICK_LAST);
    if (run) begin
      n.pre = tick ? '0 : s.pre + 1'b1;
    end

    // Write channel: address and data taken in either order
    if (S_AXI_AWVALID && s.awrdy) begin
      n.aw_ok  = 1'b1;
      n.awaddr = S_AXI_AWADDR[11:0];
    end
    if (S_AXI_WVALID && s.wrdy) begin
      n.w_ok  = 1'b1;
      n.wdata = S_AXI_WDATA[15:0];
      n.wstrb = S_AXI_WSTRB[1:0];
    end
    wr_go  = s.aw_ok && s.w_ok && !s.bvalid;
    wr_cnt = wr_go && (s.awaddr == ADDR_COUNT);
    wr_ctl = wr_go && (s.awaddr == ADDR_CTRL);
    // A partial write cannot present the key, so it never reloads
    key_ok = (s.wdata[KEY_MSB:KEY_LSB] == KEY_OPEN)
             && (s.wstrb == 2'h3);
    if (wr_go) begin
      n.aw_ok  = 1'b0;
      n.w_ok   = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = (wr_cnt || wr_ctl) ? RESP_OKAY : RESP_SLV;
    end
    if (s.bvalid && S_AXI_BREADY) begin
      n.bvalid = 1'b0;
    end
    n.awrdy = !n.aw_ok && !n.bvalid;
    n.wrdy  = !n.w_ok && !n.bvalid;

    // Control write: mode bit can only be raised by software
    if (wr_ctl && s.wstrb[0]) begin
      n.mode  = s.mode | s.wdata[MODE_BIT];
      n.spare = s.wdata[SPARE_BIT];
    end

    // Expiry: mode 1 at zero or below, mode 0 at minus 16 or below
    if (s.mode) begin
      rst_hit = s.cnt[SIGN_BIT] || (s.cnt == CNT_ZERO);
    end else begin
      rst_hit = s.cnt[SIGN_BIT] && (s.cnt <= CNT_NEG16);
    end
    nmi_hit = !s.mode && (s.cnt == CNT_ZERO);

    // Count: expiry beats a reload, which beats a tick
    if (rst_hit) begin
      n.cnt  = CNT_RST;
      n.mode = 1'b0;
      n.pre  = '0;
    end else if (wr_cnt && key_ok) begin
      n.cnt = {1'b0, s.wdata[7:0]};
    end else if (tick) begin
      n.cnt = s.cnt - CNT_ONE;
    end
    n.nmi  = nmi_hit;
    n.srst = rst_hit;

    // Read channel: count reads back live, not the reload value
    rd_cnt = s.cnt;
    if (S_AXI_ARVALID && s.arrdy) begin
      n.rvalid = 1'b1;
      n.rresp  = RESP_OKAY;
      if (S_AXI_ARADDR[11:0] == ADDR_COUNT) begin
        n.rdata = {23'h000000, rd_cnt};
      end else if (S_AXI_ARADDR[11:0] == ADDR_CTRL) begin
        n.rdata = {30'h00000000, s.spare, s.mode};
      end else begin
        n.rdata = 32'h0000_0000;
        n.rresp = RESP_SLV;
      end
    end
    if (s.rvalid && S_AXI_RREADY) begin
      n.rvalid = 1'b0;
    end
    n.arrdy = !n.rvalid;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s     <= '0;
      s.cnt <= CNT_RST;
    end else begin
      s <= n;
    end
  end

  assign NMI_O         = s.nmi;
  assign SYS_RST_REQ   = s.srst;
  assign S_AXI_AWREADY = s.awrdy;
  assign S_AXI_WREADY  = s.wrdy;
  assign S_AXI_BVALID  = s.bvalid;
  assign S_AXI_BRESP   = s.bresp;
  assign S_AXI_ARREADY = s.arrdy;
  assign S_AXI_RVALID  = s.rvalid;
  assign S_AXI_RDATA   = s.rdata;
  assign S_AXI_RRESP   = s.rresp;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  bad_key_a: assert property (
    wr_cnt && !key_ok && !rst_hit && !tick |=> $stable(s.cnt))
    else $error("count changed on a locked write");

  reload_val_a: assert property (
    wr_cnt && key_ok && !rst_hit
    |=> s.cnt == {1'b0, $past(s.wdata[7:0])})
    else $error("reload value not taken");

  tick_dec_a: assert property (
    tick && !rst_hit && !(wr_cnt && key_ok)
    |=> s.cnt == $past(s.cnt) - CNT_ONE)
    else $error("tick did not decrement by one");

  zero_wrap_a: assert property (
    tick && s.mode == 1'b0 && s.cnt == CNT_ZERO && !wr_cnt
    |=> s.cnt == 9'h1FF)
    else $error("count did not wrap to 1FF");

  live_read_a: assert property (
    S_AXI_ARVALID && s.arrdy && S_AXI_ARADDR[11:0] == ADDR_COUNT
    |=> S_AXI_RVALID && S_AXI_RDATA[8:0] == $past(s.cnt))
    else $error("read did not return live count");

  nmi_zero_a: assert property (
    ##1 NMI_O |-> $past(!s.mode && s.cnt == CNT_ZERO))
    else $error("interrupt without zero count in mode 0");

  neg16_rst_a: assert property (
    !s.mode && s.cnt == CNT_NEG16
    |=> SYS_RST_REQ && s.cnt == CNT_RST ##1 !SYS_RST_REQ)
    else $error("no reset and reload at minus 16");

  mode1_rst_a: assert property (
    s.mode && (s.cnt == CNT_ZERO || s.cnt[SIGN_BIT])
    |=> SYS_RST_REQ && !NMI_O && !s.mode)
    else $error("mode 1 expiry wrong");

  sticky_mode_a: assert property (
    s.mode && !rst_hit |=> s.mode)
    else $error("mode bit cleared without reset");

  halt_hold_a: assert property (
    (halt || (s.frz && !s.mode)) && !rst_hit && !wr_cnt
    |=> $stable(s.cnt) && $stable(s.pre))
    else $error("count moved while frozen");

  mode1_run_a: assert property (
    s.mode && !halt && !rst_hit |=> s.pre != $past(s.pre))
    else $error("mode 1 counting was frozen");

  // ----------------------------------------------------------------
  // Bus handshake checks
  // ----------------------------------------------------------------
  // A held address or data beat, or a pending response, must keep its channel closed
  aw_closed_a: assert property (
    s.aw_ok || S_AXI_BVALID |-> !S_AXI_AWREADY)
    else $error("write address taken while busy");

  w_closed_a: assert property (
    s.w_ok || S_AXI_BVALID |-> !S_AXI_WREADY)
    else $error("write data taken while busy");

  ar_closed_a: assert property (
    S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address taken while busy");

  bresp_hold_a: assert property (
    S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");

  rdata_hold_a: assert property (
    S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP))
    else $error("read data dropped early");

  bresp_done_a: assert property (
    S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response not retired");

  rdata_done_a: assert property (
    S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read data not retired");

  write_answer_a: assert property (
    wr_go |=> S_AXI_BVALID)
    else $error("write not answered");

  bad_waddr_a: assert property (
    wr_go && !wr_cnt && !wr_ctl |=> S_AXI_BRESP == RESP_SLV)
    else $error("unmapped write not refused");

  bad_raddr_a: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY
    && S_AXI_ARADDR[11:0] != ADDR_COUNT
    && S_AXI_ARADDR[11:0] != ADDR_CTRL
    |=> S_AXI_RRESP == RESP_SLV && S_AXI_RDATA == 32'h0000_0000)
    else $error("unmapped read not refused");

  // ----------------------------------------------------------------
  // Watchdog checks
  // ----------------------------------------------------------------
  ctrl_read_a: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[11:0] == ADDR_CTRL
    |=> S_AXI_RDATA[MODE_BIT] == $past(s.mode))
    else $error("control read lost the mode bit");

  mode_set_a: assert property (
    wr_ctl && s.wstrb[0] && s.wdata[MODE_BIT] && !rst_hit |=> s.mode)
    else $error("mode bit write not taken");

  rst_reload_a: assert property (
    SYS_RST_REQ |-> s.cnt == CNT_RST && !s.mode)
    else $error("reset did not reload the count");

  rst_pulse_a: assert property (
    SYS_RST_REQ |=> !SYS_RST_REQ)
    else $error("reset request longer than one cycle");

  zero_nmi_a: assert property (
    !s.mode && s.cnt == CNT_ZERO |=> NMI_O)
    else $error("no interrupt at zero count");

  mode1_quiet_a: assert property (
    s.mode |=> !NMI_O)
    else $error("interrupt raised in mode 1");

  pre_range_a: assert property (
    s.pre <= TICK_LAST)
    else $error("prescaler ran past its end");

  frz_set_a: assert property (
    s.sync2[0] |=> s.frz)
    else $error("freeze request not latched");

  frz_clear_a: assert property (
    s.sync2[1] && !s.sync2[0] |=> !s.frz)
    else $error("resume request not latched");

  strobe_lock_a: assert property (
    wr_cnt && s.wstrb != 2'h3 && !rst_hit && !tick |=> $stable(s.cnt))
    else $error("count changed on a partial write");

  halt_stop_a: assert property (
    halt && !rst_hit |=> $stable(s.pre))
    else $error("prescaler moved in debug halt");

endmodule : wdg_top

/* core/wdg_pkg.sv */
// Package: constants and state record of the countdown watchdog
package wdg_pkg;

  // ----------------------------------------------------------------
  // Register map (printed offsets are word indices)
  // ----------------------------------------------------------------
  localparam logic [31:0] IDX_COUNT  = 32'h5000_3100;
  localparam logic [31:0] IDX_CTRL   = 32'h5000_3102;
  localparam logic [11:0] ADDR_COUNT = {IDX_COUNT[9:0], 2'b00};
  localparam logic [11:0] ADDR_CTRL  = {IDX_CTRL[9:0], 2'b00};

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int          KEY_MSB   = 15;
  localparam int          KEY_LSB   = 9;
  localparam logic [6:0]  KEY_OPEN  = 7'h00;
  localparam int          SIGN_BIT  = 8;
  localparam int          MODE_BIT  = 0;
  localparam int          SPARE_BIT = 1;
  localparam logic [8:0]  CNT_RST   = 9'h0FF;
  localparam logic [8:0]  CNT_ZERO  = 9'h000;
  localparam logic [8:0]  CNT_ONE   = 9'h001;
  localparam logic [8:0]  CNT_NEG16 = 9'h1F0;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLV  = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned TICK_PERIOD_US = 10240;
  localparam int unsigned TICK_CYC_DFLT =
    (TICK_PERIOD_US * 1000) / (CLK_PERIOD_PS / 1000);
  localparam int          PRE_W = 24;

  // ----------------------------------------------------------------
  // Whole module state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]       sync1;
    logic [2:0]       sync2;
    logic             frz;
    logic             mode;
    logic             spare;
    logic [8:0]       cnt;
    logic [PRE_W-1:0] pre;
    logic             nmi;
    logic             srst;
    logic             aw_ok;
    logic [11:0]      awaddr;
    logic             w_ok;
    logic [15:0]      wdata;
    logic [1:0]       wstrb;
    logic             awrdy;
    logic             wrdy;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arrdy;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } wdg_state_t;

endpackage : wdg_pkg

/* testbench/wdg_host_model.sv */
// Far-side model: processor interrupt input and system reset controller
`timescale 1ns/1ps

module wdg_host_model (
  input  wire logic clk,       // Core clock
  input  wire logic nmi,       // Interrupt line from the watchdog
  input  wire logic rst_req,   // Reset request from the watchdog
  output int        nmi_seen,  // Interrupt rising edges seen
  output int        rst_seen   // Cycles with reset request high
);
  logic nmi_q;

  initial begin
    nmi_q    = 1'b0;
    nmi_seen = 0;
    rst_seen = 0;
  end

  // Mid-cycle sampling: registered outputs are settled by then
  always @(negedge clk) begin
    if (nmi === 1'b1 && !nmi_q) nmi_seen++;
    if (rst_req === 1'b1) rst_seen++;
    nmi_q <= (nmi === 1'b1);
  end
endmodule : wdg_host_model

/* testbench/wdg_top_tb_top.sv */
// Self-checking bench for the countdown watchdog
`timescale 1ns/1ps

module wdg_top_tb_top;
  import wdg_pkg::*;
  // Short tick keeps the run brief; every timing expectation derives from it
  localparam int TICK  = 8;
  localparam int LIMIT = 5000;
  logic        clk = 1'b0, rst_b = 1'b0, halt = 1'b1;
  logic        frz_set = 1'b0, frz_clr = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0;
  logic        rready = 1'b0, awr, wr_r, bv, arr, rv, nmi, srst;
  logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rdata;
  logic [1:0]  bresp, rresp;
  logic [7:0]  v;
  logic [3:0]  wst = 4'hF;
  logic [33:0] expq[$];
  int          fails = 0, compares = 0, cyc = 0, nmi_n, rst_n, n;

  initial forever #2 clk = ~clk;

  wdg_top #(.TICK_CYCLES(TICK)) wdg_top_inst (
    .CORE_CLK(clk), .RST_B(rst_b), .FRZ_SET(frz_set), .FRZ_CLR(frz_clr),
    .DBG_HALT(halt), .NMI_O(nmi), .SYS_RST_REQ(srst),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa),
    .S_AXI_AWPROT(3'h0), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(wst), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_ARPROT(3'h0),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp)
  );

  wdg_host_model wdg_host_model_inst (
    .clk(clk), .nmi(nmi), .rst_req(srst), .nmi_seen(nmi_n), .rst_seen(rst_n)
  );

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [33:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_of_test;
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      fails++;
      end_of_test;
    end
  end

  // Read results are compared mid-cycle, ahead of the handshake edge
  always @(negedge clk) begin
    if (rv === 1'b1 && rready) begin
      chk("rdata", {rresp, rdata}, expq.pop_front());
    end
  end

  // ----------------------------------------------------------------
  // Bus master tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic da, dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge clk);
    awv    <= 1'b1;
    wv     <= 1'b1;
    awa    <= {20'h0, a};
    wd     <= {16'h0, d};
    bready <= 1'b1;
    while (!(da && dw)) begin
      @(negedge clk);
      if (awr === 1'b1 && !da) da = 1'b1;
      else if (da) da = 1'b1;
      if (wr_r === 1'b1 && !dw) dw = 1'b1;
      @(posedge clk);
      if (da) awv <= 1'b0;
      if (dw) wv <= 1'b0;
    end
    do @(negedge clk); while (bv !== 1'b1);
    chk("bresp", {32'h0, bresp}, {32'h0, RESP_OKAY});
    @(posedge clk);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [33:0] exp);
    expq.push_back(exp);
    @(posedge clk);
    arv    <= 1'b1;
    ara    <= {20'h0, a};
    rready <= 1'b1;
    do @(negedge clk); while (arr !== 1'b1);
    @(posedge clk);
    arv <= 1'b0;
    do @(negedge clk); while (rv !== 1'b1);
    @(posedge clk);
    rready <= 1'b0;
  endtask : rd

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(33534));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rd(ADDR_COUNT, {RESP_OKAY, 23'h0, CNT_RST});
    rd(ADDR_CTRL, {RESP_OKAY, 32'h0});
    rd(12'h010, {RESP_SLV, 32'h0});
    // Debug halt holds the count still, so read-back is exact
    repeat (3) begin
      v = 8'($urandom);
      wr(ADDR_COUNT, {8'h00, v});
      rd(ADDR_COUNT, {RESP_OKAY, 24'h0, v});
    end
    // A partial write carries no full key, so it must not reload
    wst <= 4'h1;
    wr(ADDR_COUNT, 16'h0012);
    wst <= 4'hF;
    rd(ADDR_COUNT, {RESP_OKAY, 24'h0, v});
    wr(ADDR_COUNT, {7'($urandom) | 7'h01, 9'h012});
    rd(ADDR_COUNT, {RESP_OKAY, 24'h0, v});
    wr(ADDR_COUNT, 16'h0040);
    frz_set <= 1'b1;
    repeat (4) @(posedge clk);
    frz_set <= 1'b0;
    halt    <= 1'b0;
    repeat (100) @(posedge clk);
    rd(ADDR_COUNT, {RESP_OKAY, 32'h40});
    frz_clr <= 1'b1;
    repeat (4) @(posedge clk);
    frz_clr <= 1'b0;
    do @(negedge clk); while (nmi !== 1'b1);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (srst !== 1'b1);
    chk("gap", 34'(n), 34'(16 * TICK));
    rd(ADDR_COUNT, {RESP_OKAY, 23'h0, CNT_RST});
    chk("reset cycles", 34'(rst_n), 34'h1);
    // Freeze latch set, then direct-reset mode must ignore it
    frz_set <= 1'b1;
    repeat (4) @(posedge clk);
    frz_set <= 1'b0;
    halt    <= 1'b1;
    repeat (4) @(posedge clk);
    wr(ADDR_COUNT, 16'h0003);
    wr(ADDR_CTRL, 16'h0001);
    wr(ADDR_CTRL, 16'h0000);
    rd(ADDR_CTRL, {RESP_OKAY, 32'h1});
    halt <= 1'b0;
    do @(negedge clk); while (srst !== 1'b1);
    rd(ADDR_COUNT, {RESP_OKAY, 23'h0, CNT_RST});
    rd(ADDR_CTRL, {RESP_OKAY, 32'h0});
    chk("interrupts", 34'(nmi_n), 34'h1);
    end_of_test;
  end
endmodule : wdg_top_tb_top
